// ---- verilog/ohtc_cfg.svh ----
// Constants for the output hold timers and their parameter store.
// Assumes a single 40 MHz reference clock; included by bare name.
`ifndef OHTC_CFG_SVH
`define OHTC_CFG_SVH

`define OHTC_CLK_KHZ 40000
`define OHTC_TICK_MS 100
`define OHTC_REBOOT_MS 100
`define OHTC_NV_WRITE_CYCLES 16

`define OHTC_NLINES 11
`define OHTC_NPARAM 14
`define OHTC_IDX_PWM_HOLD 11
`define OHTC_IDX_CHAN_A_DUTY 12
`define OHTC_IDX_CHAN_B_DUTY 13

`define OHTC_MAX_TIMEOUT 16'h1770
`define OHTC_MAX_DUTY 16'h03FF
`define OHTC_RST_TIMEOUT 16'h0000
`define OHTC_RST_PWM_HOLD 16'h00FF
`define OHTC_RST_DUTY 16'h0000

`endif

// ---- verilog/ohtc_pkg.sv ----
// Types shared by the hold timer block.
// Assumes ohtc_cfg.svh is on the include path.
`default_nettype none

package ohtc_pkg;
  typedef logic [15:0] ohtc_word_t;
  typedef logic [9:0] ohtc_duty_t;

  typedef enum logic [3:0] {
    OHTC_CMD_WRITE = 4'h0,
    OHTC_CMD_READ = 4'h1,
    OHTC_CMD_APPLY = 4'h2,
    OHTC_CMD_COMMIT = 4'h3,
    OHTC_CMD_REBOOT = 4'h4,
    OHTC_CMD_DEFAULTS = 4'h5,
    OHTC_CMD_SET_CUSTOM = 4'h6,
    OHTC_CMD_CLEAR_CUSTOM = 4'h7,
    OHTC_CMD_FACTORY = 4'h8
  } ohtc_cmd_e;

  typedef enum {
    OHTC_ST_IDLE,
    OHTC_ST_COMMIT,
    OHTC_ST_REBOOT
  } ohtc_state_e;
endpackage

`default_nettype wire

// ---- verilog/ohtc_hold_if.sv ----
// Carrier between the parameter store and one hold timer.
// Assumes both ends run on the same clock.
`default_nettype none

interface ohtc_hold_if;
  logic tick;
  logic load;
  logic [15:0] period;
  logic expired;
  logic running;

  modport timer (input tick, input load, input period, output expired, output running);
  modport owner (output tick, output load, output period, input expired, input running);
endinterface

`default_nettype wire

// ---- verilog/ohtc_hold_timer.sv ----
// One hold timer counting down in 100 ms ticks.
// Assumes tick is a one-cycle enable on the same clock.
`default_nettype none

module ohtc_hold_timer (
  input wire logic ref_clk,
  input wire logic rst,
  ohtc_hold_if.timer hif
);
  logic [15:0] count_q;
  logic expired_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count_q <= 16'h0000;
    end else if (hif.load) begin
      count_q <= hif.period;
    end else if (hif.tick && count_q != 16'h0000) begin
      count_q <= count_q - 16'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      expired_q <= 1'b0;
    end else begin
      expired_q <= !hif.load && hif.tick && count_q == 16'h0001;
    end
  end

  assign hif.expired = expired_q;
  assign hif.running = count_q != 16'h0000;
endmodule // ohtc_hold_timer

`default_nettype wire

// ---- verilog/ohtc_output_hold.sv ----
// Output hold timers for eleven lines and two PWM channels, with the
// parameter store that feeds them (pending, live, stored, custom).
// Assumes all inputs come from logic on ref_clk.
//
// How it works
// - Driven line reverts after hold time
// - Hold counts 100 ms units, max 0x1770
// - Zero hold time keeps driven value forever
// - Separate timer per line two to twelve
// - Shared PWM timer restores each duty setting
// - PWM timer acts only in PWM mode
// - Apply puts pending settings live at once
// - Commit stores values, live after reset
// - Reboot: OK now, reset 100 ms later
// - Restore loads custom defaults else factory
// - After set-custom, next write updates both
// - Clear-custom erases customs, live untouched
// - Factory restore ignores custom defaults
// - Custom-default commands refused when remote
// - Duty settings are 10-bit, up to 0x3FF
`default_nettype none
`include "ohtc_cfg.svh"

module ohtc_output_hold
  import ohtc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `OHTC_TICK_MS * `OHTC_CLK_KHZ,
  parameter int unsigned REBOOT_CYCLES = `OHTC_REBOOT_MS * `OHTC_CLK_KHZ
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire ohtc_cmd_e cmd_op,
  input wire logic [3:0] cmd_index,
  input wire logic [15:0] cmd_wdata,
  input wire logic cmd_remote,
  output logic rsp_valid,
  output logic rsp_ok,
  output logic [15:0] rsp_rdata,
  output logic cmd_busy,
  output logic cmd_mode_end,
  output logic sys_reset_req,
  input wire logic [10:0] line_drive,
  input wire logic [10:0] line_drive_level,
  input wire logic [10:0] line_cfg_level,
  output logic [10:0] line_out,
  input wire logic [1:0] pwm_mode_en,
  input wire logic pwm_drive,
  input wire logic [9:0] pwm_drive_duty_a,
  input wire logic [9:0] pwm_drive_duty_b,
  output logic [9:0] pwm_duty_a,
  output logic [9:0] pwm_duty_b
);
  localparam int NPARAM = `OHTC_NPARAM;
  localparam int NLINES = `OHTC_NLINES;

  ohtc_state_e state_q;
  logic [31:0] tick_cnt_q;
  logic tick_q;
  logic [31:0] wait_cnt_q;
  logic boot_q;
  logic cust_arm_q;
  logic reboot_fire;
  ohtc_word_t pending_q [NPARAM];
  ohtc_word_t live_q [NPARAM];
  ohtc_word_t nv_q [NPARAM];
  logic nv_valid_q = 1'b0;
  ohtc_word_t cust_q [NPARAM];
  logic [NPARAM-1:0] cust_valid_q;
  logic rsp_valid_q;
  logic rsp_ok_q;
  logic [15:0] rsp_rdata_q;
  logic mode_end_q;
  logic reset_req_q;
  logic [10:0] line_q;
  logic [10:0] line_ov_q;
  logic [1:0] pwm_ov_q;
  ohtc_duty_t pwm_q [2];

  logic accept;
  logic idx_ok;
  logic range_ok;
  logic refused;
  logic write_ok;
  logic custom_write;

  function automatic ohtc_word_t factory_value(input int idx);
    factory_value = (idx == `OHTC_IDX_PWM_HOLD) ? `OHTC_RST_PWM_HOLD :
                    (idx >= `OHTC_IDX_CHAN_A_DUTY) ? `OHTC_RST_DUTY : `OHTC_RST_TIMEOUT;
  endfunction

  // Command decode
  always_comb begin
    accept = cmd_valid && state_q == OHTC_ST_IDLE && !boot_q;
    idx_ok = cmd_index < 4'(NPARAM);
    range_ok = (cmd_index >= 4'(`OHTC_IDX_CHAN_A_DUTY)) ? cmd_wdata <= `OHTC_MAX_DUTY
                                                        : cmd_wdata <= `OHTC_MAX_TIMEOUT;
    refused = cmd_remote && (cmd_op == OHTC_CMD_SET_CUSTOM || cmd_op == OHTC_CMD_CLEAR_CUSTOM);
    write_ok = accept && cmd_op == OHTC_CMD_WRITE && idx_ok && range_ok;
    custom_write = write_ok && cust_arm_q;
  end

  // 100 ms tick divider
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tick_cnt_q <= 32'h00000000;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == 32'(TICK_CYCLES - 1)) begin
      tick_cnt_q <= 32'h00000000;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h00000001;
      tick_q <= 1'b0;
    end
  end

  // Boot load of stored values, one cycle after reset release
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      boot_q <= 1'b1;
    end else begin
      boot_q <= 1'b0;
    end
  end

  // Sequencer for commit and delayed reboot
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= OHTC_ST_IDLE;
      wait_cnt_q <= 32'h00000000;
    end else begin
      case (state_q)
        OHTC_ST_IDLE: begin
          wait_cnt_q <= 32'h00000000;
          if (accept && cmd_op == OHTC_CMD_COMMIT) begin
            state_q <= OHTC_ST_COMMIT;
          end else if (accept && cmd_op == OHTC_CMD_REBOOT) begin
            state_q <= OHTC_ST_REBOOT;
          end
        end
        OHTC_ST_COMMIT: begin
          wait_cnt_q <= wait_cnt_q + 32'h00000001;
          if (wait_cnt_q == 32'(`OHTC_NV_WRITE_CYCLES - 1)) begin
            state_q <= OHTC_ST_IDLE;
          end
        end
        OHTC_ST_REBOOT: begin
          wait_cnt_q <= wait_cnt_q + 32'h00000001;
          if (reboot_fire) begin
            state_q <= OHTC_ST_IDLE;
          end
        end
        default: begin
          state_q <= OHTC_ST_IDLE;
        end
      endcase
    end
  end

  assign reboot_fire = state_q == OHTC_ST_REBOOT && wait_cnt_q == 32'(REBOOT_CYCLES - 1);

  // Arming of the set-custom-default prefix
  always_ff @(posedge ref_clk) begin
    if (rst || reboot_fire) begin
      cust_arm_q <= 1'b0;
    end else if (accept) begin
      cust_arm_q <= cmd_op == OHTC_CMD_SET_CUSTOM && !refused;
    end
  end

  // Pending (written, not yet live) settings
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < NPARAM; i++) begin
      if (rst) begin
        pending_q[i] <= factory_value(i);
      end else if (boot_q || reboot_fire) begin
        pending_q[i] <= nv_valid_q ? nv_q[i] : factory_value(i);
      end else if (accept && cmd_op == OHTC_CMD_DEFAULTS) begin
        pending_q[i] <= cust_valid_q[i] ? cust_q[i] : factory_value(i);
      end else if (accept && cmd_op == OHTC_CMD_FACTORY) begin
        pending_q[i] <= factory_value(i);
      end else if (write_ok && cmd_index == 4'(i)) begin
        pending_q[i] <= cmd_wdata;
      end
    end
  end

  // Live settings that steer the timers
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < NPARAM; i++) begin
      if (rst) begin
        live_q[i] <= factory_value(i);
      end else if (boot_q || reboot_fire) begin
        live_q[i] <= nv_valid_q ? nv_q[i] : factory_value(i);
      end else if (accept && cmd_op == OHTC_CMD_DEFAULTS) begin
        live_q[i] <= cust_valid_q[i] ? cust_q[i] : factory_value(i);
      end else if (accept && cmd_op == OHTC_CMD_FACTORY) begin
        live_q[i] <= factory_value(i);
      end else if (accept && cmd_op == OHTC_CMD_APPLY) begin
        live_q[i] <= pending_q[i];
      end else if (custom_write && cmd_index == 4'(i)) begin
        live_q[i] <= cmd_wdata;
      end
    end
  end

  // Non-volatile copy: survives rst, written only by commit
  always_ff @(posedge ref_clk) begin
    if (accept && cmd_op == OHTC_CMD_COMMIT) begin
      nv_valid_q <= 1'b1;
      for (int i = 0; i < NPARAM; i++) begin
        nv_q[i] <= pending_q[i];
      end
    end
  end

  // Custom-default store
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cust_valid_q <= '0;
      for (int i = 0; i < NPARAM; i++) begin
        cust_q[i] <= 16'h0000;
      end
    end else if (accept && cmd_op == OHTC_CMD_CLEAR_CUSTOM && !refused) begin
      cust_valid_q <= '0;
    end else if (custom_write) begin
      cust_valid_q[cmd_index] <= 1'b1;
      cust_q[cmd_index] <= cmd_wdata;
    end
  end

  // Command answers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rsp_valid_q <= 1'b0;
      rsp_ok_q <= 1'b0;
      rsp_rdata_q <= 16'h0000;
    end else if (state_q == OHTC_ST_COMMIT) begin
      rsp_valid_q <= wait_cnt_q == 32'(`OHTC_NV_WRITE_CYCLES - 1);
      rsp_ok_q <= 1'b1;
      rsp_rdata_q <= 16'h0000;
    end else if (accept && cmd_op != OHTC_CMD_COMMIT) begin
      rsp_valid_q <= 1'b1;
      rsp_rdata_q <= (cmd_op == OHTC_CMD_READ && idx_ok) ? pending_q[cmd_index] : 16'h0000;
      case (cmd_op)
        OHTC_CMD_WRITE: rsp_ok_q <= idx_ok && range_ok;
        OHTC_CMD_READ: rsp_ok_q <= idx_ok;
        OHTC_CMD_SET_CUSTOM, OHTC_CMD_CLEAR_CUSTOM: rsp_ok_q <= !refused;
        OHTC_CMD_APPLY, OHTC_CMD_REBOOT, OHTC_CMD_DEFAULTS, OHTC_CMD_FACTORY: rsp_ok_q <= 1'b1;
        default: rsp_ok_q <= 1'b0;
      endcase
    end else begin
      rsp_valid_q <= 1'b0;
      rsp_ok_q <= 1'b0;
      rsp_rdata_q <= 16'h0000;
    end
  end

  // Reboot strobes and busy flag
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_end_q <= 1'b0;
      reset_req_q <= 1'b0;
      cmd_busy <= 1'b1;
    end else begin
      mode_end_q <= reboot_fire;
      reset_req_q <= reboot_fire;
      cmd_busy <= (state_q != OHTC_ST_IDLE && !reboot_fire &&
                   !(state_q == OHTC_ST_COMMIT && wait_cnt_q == 32'(`OHTC_NV_WRITE_CYCLES - 1))) ||
                  (accept && (cmd_op == OHTC_CMD_COMMIT || cmd_op == OHTC_CMD_REBOOT));
    end
  end

  // One timer per line, plus the shared PWM timer at the last slot
  ohtc_hold_if hif [NLINES+1] ();

  genvar g;
  generate
    for (g = 0; g <= NLINES; g++) begin : g_timer
      ohtc_hold_timer u_timer (
        .ref_clk(ref_clk),
        .rst(rst),
        .hif(hif[g])
      );
      assign hif[g].tick = tick_q;
      assign hif[g].period = reboot_fire ? 16'h0000 : live_q[g];
      if (g < NLINES) begin : g_line
        assign hif[g].load = reboot_fire || line_drive[g];
      end else begin : g_pwm
        assign hif[g].load = reboot_fire || (pwm_drive && |pwm_mode_en);
      end
    end

    for (g = 0; g < NLINES; g++) begin : g_line_out
      always_ff @(posedge ref_clk) begin
        if (rst || reboot_fire) begin
          line_ov_q[g] <= 1'b0;
        end else if (line_drive[g]) begin
          line_ov_q[g] <= 1'b1;
        end else if (hif[g].expired) begin
          line_ov_q[g] <= 1'b0;
        end
      end

      always_ff @(posedge ref_clk) begin
        if (rst) begin
          line_q[g] <= 1'b0;
        end else if (line_drive[g]) begin
          line_q[g] <= line_drive_level[g];
        end else if (!line_ov_q[g] || hif[g].expired || reboot_fire) begin
          line_q[g] <= line_cfg_level[g];
        end
      end
    end

    for (g = 0; g < 2; g++) begin : g_pwm_out
      always_ff @(posedge ref_clk) begin
        if (rst || reboot_fire) begin
          pwm_ov_q[g] <= 1'b0;
        end else if (pwm_drive && pwm_mode_en[g]) begin
          pwm_ov_q[g] <= 1'b1;
        end else if (hif[NLINES].expired || !pwm_mode_en[g]) begin
          pwm_ov_q[g] <= 1'b0;
        end
      end

      always_ff @(posedge ref_clk) begin
        if (rst) begin
          pwm_q[g] <= 10'(`OHTC_RST_DUTY);
        end else if (pwm_drive && pwm_mode_en[g]) begin
          pwm_q[g] <= (g == 0) ? pwm_drive_duty_a : pwm_drive_duty_b;
        end else if (!pwm_ov_q[g] || hif[NLINES].expired) begin
          pwm_q[g] <= live_q[`OHTC_IDX_CHAN_A_DUTY + g][9:0];
        end
      end
    end
  endgenerate

  assign rsp_valid = rsp_valid_q;
  assign rsp_ok = rsp_ok_q;
  assign rsp_rdata = rsp_rdata_q;
  assign cmd_mode_end = mode_end_q;
  assign sys_reset_req = reset_req_q;
  assign line_out = line_q;
  assign pwm_duty_a = pwm_q[0];
  assign pwm_duty_b = pwm_q[1];
endmodule // ohtc_output_hold

`default_nettype wire

// ---- verif/ohtc_output_hold_asserts.sv ----
// Checker for the hold timer block, bound to its top module.
// Assumes one clock and a synchronous active-high reset.
`default_nettype none

module ohtc_output_hold_asserts
  import ohtc_pkg::*;
#(
  parameter int unsigned REBOOT_CYCLES = 10
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire ohtc_cmd_e cmd_op,
  input wire logic [3:0] cmd_index,
  input wire logic [15:0] cmd_wdata,
  input wire logic cmd_remote,
  input wire logic rsp_valid,
  input wire logic rsp_ok,
  input wire logic cmd_busy,
  input wire logic cmd_mode_end,
  input wire logic sys_reset_req,
  input wire logic [10:0] line_drive,
  input wire logic [10:0] line_drive_level,
  input wire logic [10:0] line_cfg_level,
  input wire logic [10:0] line_out
);
  logic take;
  logic [31:0] reb_cnt_q;
  assign take = cmd_valid && !cmd_busy;

  // Cycles since a reboot request was taken
  always_ff @(posedge ref_clk) begin
    if (rst) reb_cnt_q <= 32'h0;
    else if (take && cmd_op == OHTC_CMD_REBOOT) reb_cnt_q <= 32'h1;
    else if (sys_reset_req) reb_cnt_q <= 32'h0;
    else if (reb_cnt_q != 32'h0) reb_cnt_q <= reb_cnt_q + 32'h1;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  AST_TIMEOUT_RANGE: assert property (take && cmd_op == OHTC_CMD_WRITE && cmd_index <= 4'hB
    && cmd_wdata > 16'h1770 |=> rsp_valid && !rsp_ok) else $error("hold time over range accepted");
  AST_DUTY_RANGE: assert property (take && cmd_op == OHTC_CMD_WRITE && cmd_index >= 4'hC
    && cmd_index <= 4'hD && cmd_wdata > 16'h03FF |=> rsp_valid && !rsp_ok) else $error("duty over range accepted");
  AST_REMOTE_REFUSE: assert property (take && cmd_remote && (cmd_op == OHTC_CMD_SET_CUSTOM
    || cmd_op == OHTC_CMD_CLEAR_CUSTOM) |=> rsp_valid && !rsp_ok) else $error("remote custom command accepted");
  AST_REBOOT_OK: assert property (take && cmd_op == OHTC_CMD_REBOOT |=> rsp_valid && rsp_ok && cmd_busy)
    else $error("reboot not answered at once");
  AST_REBOOT_FIRE: assert property (sys_reset_req == (reb_cnt_q == REBOOT_CYCLES + 32'h1))
    else $error("reboot fired at wrong time");
  AST_MODE_END: assert property (sys_reset_req == cmd_mode_end)
    else $error("command mode end not with reset");
  AST_COMMIT: assert property (take && cmd_op == OHTC_CMD_COMMIT |=> (cmd_busy && !rsp_valid)[*8]
    ##9 (rsp_valid && rsp_ok && !cmd_busy)) else $error("commit answer timing wrong");
  AST_DRIVE: assert property (|line_drive && !cmd_busy
    |=> ((line_out ^ $past(line_drive_level)) & $past(line_drive)) == 11'h000) else $error("driven level lost");
  AST_REVERT: assert property (((line_out ^ $past(line_out)) & ~$past(line_drive)
    & (line_out ^ $past(line_cfg_level))) == 11'h000) else $error("line moved to other than config");

  cover property (take && cmd_op == OHTC_CMD_COMMIT);
  cover property (sys_reset_req);
  cover property (take && cmd_remote && cmd_op == OHTC_CMD_SET_CUSTOM);
endmodule // ohtc_output_hold_asserts

bind ohtc_output_hold ohtc_output_hold_asserts #(.REBOOT_CYCLES(REBOOT_CYCLES)) u_asserts (
  .ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_index(cmd_index),
  .cmd_wdata(cmd_wdata), .cmd_remote(cmd_remote), .rsp_valid(rsp_valid), .rsp_ok(rsp_ok),
  .cmd_busy(cmd_busy), .cmd_mode_end(cmd_mode_end), .sys_reset_req(sys_reset_req), .line_drive(line_drive),
  .line_drive_level(line_drive_level), .line_cfg_level(line_cfg_level), .line_out(line_out));

`default_nettype wire

// ---- verif/ohtc_host_model.sv ----
// Host that issues configuration commands to the block.
// Assumes requests are one-cycle pulses sampled on ref_clk.
`default_nettype none

module ohtc_host_model
  import ohtc_pkg::*;
(
  input wire logic ref_clk,
  output logic cmd_valid,
  output ohtc_cmd_e cmd_op,
  output logic [3:0] cmd_index,
  output logic [15:0] cmd_wdata,
  output logic cmd_remote,
  input wire logic rsp_valid,
  input wire logic rsp_ok,
  input wire logic [15:0] rsp_rdata,
  input wire logic cmd_busy
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    cmd_valid = 1'b0;
    cmd_op = OHTC_CMD_READ;
    cmd_index = 4'h0;
    cmd_wdata = 16'h0000;
    cmd_remote = 1'b0;
  end

  task automatic send(input ohtc_cmd_e op, input logic [3:0] idx, input logic [15:0] d, input logic rem,
                      output logic ok, output logic [15:0] rd);
    int n;
    n = 0;
    ok = 1'b0;
    rd = 16'h0000;
    @(negedge ref_clk);
    // Wait up to 40 cycles for a running commit or reboot to finish before sending
    while (cmd_busy && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_index = idx;
    cmd_wdata = d;
    cmd_remote = rem;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    cmd_index = ~idx;
    cmd_wdata = ~d;
    n = 0;
    // Wait for the answer before anything else
    do begin
      @(posedge ref_clk);
      n++;
    end while (!rsp_valid && n < 40);
    ok = rsp_valid & rsp_ok;
    rd = rsp_rdata;
  endtask
endmodule // ohtc_host_model

`default_nettype wire

// ---- verif/ohtc_output_hold_tb.sv ----
// Self-checking bench for the output hold timer block.
// Assumes the host model and the bound checker are compiled with it.
`default_nettype none

module ohtc_output_hold_tb import ohtc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TK = 20;
  localparam int RB = 10;
  logic ref_clk, rst, cmd_valid, cmd_remote, rsp_valid, rsp_ok, cmd_busy, cmd_mode_end, sys_reset_req, ok;
  logic pwm_drive;
  ohtc_cmd_e cmd_op;
  logic [3:0] cmd_index;
  logic [15:0] cmd_wdata, rsp_rdata, rd;
  logic [10:0] line_drive, line_drive_level, line_cfg_level, line_out;
  logic [1:0] pwm_mode_en;
  logic [9:0] pwm_drive_duty_a, pwm_drive_duty_b, pwm_duty_a, pwm_duty_b;
  int error_cnt = 0;
  int check_count = 0;
  int n;

  ohtc_output_hold #(.TICK_CYCLES(TK), .REBOOT_CYCLES(RB)) dut (
    .ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_index(cmd_index),
    .cmd_wdata(cmd_wdata), .cmd_remote(cmd_remote), .rsp_valid(rsp_valid), .rsp_ok(rsp_ok),
    .rsp_rdata(rsp_rdata), .cmd_busy(cmd_busy), .cmd_mode_end(cmd_mode_end), .sys_reset_req(sys_reset_req),
    .line_drive(line_drive), .line_drive_level(line_drive_level), .line_cfg_level(line_cfg_level),
    .line_out(line_out), .pwm_mode_en(pwm_mode_en), .pwm_drive(pwm_drive), .pwm_drive_duty_a(pwm_drive_duty_a),
    .pwm_drive_duty_b(pwm_drive_duty_b), .pwm_duty_a(pwm_duty_a), .pwm_duty_b(pwm_duty_b));

  ohtc_host_model host (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_index(cmd_index),
    .cmd_wdata(cmd_wdata), .cmd_remote(cmd_remote), .rsp_valid(rsp_valid), .rsp_ok(rsp_ok),
    .rsp_rdata(rsp_rdata), .cmd_busy(cmd_busy));

  initial ref_clk = 1'b0;
  always #12.5 ref_clk = ~ref_clk;

  task automatic summarize();
    if (error_cnt == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic req(input ohtc_cmd_e op, input logic [3:0] idx, input logic [15:0] d, input logic rem,
                     input logic exp_ok);
    host.send(op, idx, d, rem, ok, rd);
    chk("rsp_ok", {15'h0000, ok}, {15'h0000, exp_ok});
  endtask

  task automatic rdc(input logic [3:0] idx, input logic [15:0] exp);
    host.send(OHTC_CMD_READ, idx, 16'h0000, 1'b0, ok, rd);
    chk("rsp_rdata", rd, exp);
  endtask

  task automatic wt(input int c);
    repeat (c) @(negedge ref_clk);
  endtask

  task automatic drv(input logic [10:0] m);
    @(negedge ref_clk);
    line_drive = m;
    line_drive_level = ~line_cfg_level;
    @(negedge ref_clk);
    line_drive = 11'h000;
    line_drive_level = line_cfg_level;
  endtask

  task automatic pwm(input logic [1:0] m);
    @(negedge ref_clk);
    pwm_mode_en = m;
    pwm_drive = 1'b1;
    pwm_drive_duty_a = 10'h3FF;
    pwm_drive_duty_b = 10'h100;
    @(negedge ref_clk);
    pwm_drive = 1'b0;
  endtask

  task automatic do_reset();
    @(negedge ref_clk);
    rst = 1'b1;
    wt(16);
    rst = 1'b0;
    wt(3);
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    summarize();
  end

  initial begin
    rst = 1'b1;
    line_drive = 11'h000;
    line_drive_level = 11'h000;
    line_cfg_level = 11'h555;
    pwm_mode_en = 2'b00;
    pwm_drive = 1'b0;
    pwm_drive_duty_a = 10'h000;
    pwm_drive_duty_b = 10'h000;
    do_reset();
    chk("line_out", {5'h00, line_out}, 16'h0555);
    for (int i = 0; i < 14; i++) rdc(i[3:0], (i == 11) ? 16'h00FF : 16'h0000);
    req(OHTC_CMD_WRITE, 4'h0, 16'h1770, 1'b0, 1'b1);
    req(OHTC_CMD_WRITE, 4'h0, 16'h1771, 1'b0, 1'b0);
    req(OHTC_CMD_WRITE, 4'hC, 16'h03FF, 1'b0, 1'b1);
    req(OHTC_CMD_WRITE, 4'hC, 16'h0400, 1'b0, 1'b0);
    rdc(4'hC, 16'h03FF);
    req(OHTC_CMD_WRITE, 4'hE, 16'h0001, 1'b0, 1'b0);
    req(OHTC_CMD_READ, 4'hE, 16'h0000, 1'b0, 1'b0);
    req(OHTC_CMD_WRITE, 4'h0, 16'h0003, 1'b0, 1'b1);
    req(OHTC_CMD_WRITE, 4'hA, 16'h0001, 1'b0, 1'b1);
    req(OHTC_CMD_WRITE, 4'hB, 16'h0001, 1'b0, 1'b1);
    req(OHTC_CMD_WRITE, 4'hC, 16'h0155, 1'b0, 1'b1);
    req(OHTC_CMD_WRITE, 4'hD, 16'h02AA, 1'b0, 1'b1);
    drv(11'h401);
    wt(3 * TK + 4);
    chk("line_out", {5'h00, line_out}, 16'h0154);
    req(OHTC_CMD_APPLY, 4'h0, 16'h0000, 1'b0, 1'b1);
    drv(11'h403);
    chk("line_out", {5'h00, line_out}, 16'h0156);
    wt(TK + 4);
    chk("line_out", {5'h00, line_out}, 16'h0556);
    wt(3 * TK);
    chk("line_out", {5'h00, line_out}, 16'h0557);
    pwm(2'b00);
    chk("pwm_duty_a", {6'h00, pwm_duty_a}, 16'h0155);
    pwm(2'b01);
    chk("pwm_duty_a", {6'h00, pwm_duty_a}, 16'h03FF);
    chk("pwm_duty_b", {6'h00, pwm_duty_b}, 16'h02AA);
    wt(TK + 3);
    chk("pwm_duty_a", {6'h00, pwm_duty_a}, 16'h0155);
    req(OHTC_CMD_SET_CUSTOM, 4'h0, 16'h0000, 1'b1, 1'b0);
    req(OHTC_CMD_CLEAR_CUSTOM, 4'h0, 16'h0000, 1'b1, 1'b0);
    req(OHTC_CMD_SET_CUSTOM, 4'h0, 16'h0000, 1'b0, 1'b1);
    req(OHTC_CMD_WRITE, 4'h1, 16'h0005, 1'b0, 1'b1);
    req(OHTC_CMD_WRITE, 4'h1, 16'h0007, 1'b0, 1'b1);
    req(OHTC_CMD_DEFAULTS, 4'h0, 16'h0000, 1'b0, 1'b1);
    rdc(4'h1, 16'h0005);
    rdc(4'hB, 16'h00FF);
    req(OHTC_CMD_FACTORY, 4'h0, 16'h0000, 1'b0, 1'b1);
    rdc(4'h1, 16'h0000);
    req(OHTC_CMD_SET_CUSTOM, 4'h0, 16'h0000, 1'b0, 1'b1);
    req(OHTC_CMD_WRITE, 4'h1, 16'h0005, 1'b0, 1'b1);
    req(OHTC_CMD_CLEAR_CUSTOM, 4'h0, 16'h0000, 1'b0, 1'b1);
    rdc(4'h1, 16'h0005);
    req(OHTC_CMD_DEFAULTS, 4'h0, 16'h0000, 1'b0, 1'b1);
    rdc(4'h1, 16'h0000);
    req(OHTC_CMD_WRITE, 4'h2, 16'h0009, 1'b0, 1'b1);
    req(OHTC_CMD_COMMIT, 4'h0, 16'h0000, 1'b0, 1'b1);
    req(OHTC_CMD_FACTORY, 4'h0, 16'h0000, 1'b0, 1'b1);
    rdc(4'h2, 16'h0000);
    do_reset();
    rdc(4'h2, 16'h0009);
    req(OHTC_CMD_REBOOT, 4'h0, 16'h0000, 1'b0, 1'b1);
    n = 0;
    while (!sys_reset_req && n < 50) begin
      @(posedge ref_clk);
      n++;
    end
    chk("reboot_delay", n[15:0], RB[15:0]);
    chk("cmd_mode_end", {15'h0000, cmd_mode_end}, 16'h0001);
    summarize();
  end
endmodule // ohtc_output_hold_tb

`default_nettype wire
